// file: include/rsq_pkg.sv
// Notes on behaviour
// - reset bit 7 low holds converter control logic in reset; default 0
// - reset bit 6 low resets gain control logic; default 0
// - reset bit 5 low resets the data shaping filter; default 0
// - reset bit 4 low resets frequency correction and decision level
// - reset bit 3 low resets modulator, bit sync and sequence generator
// - reset bit 2 low resets digital synthesizer part; default 0
// - reset bit 1 low resets the power-up sequencer; default 0
// - reset bit 0 low resets calibration and lock detector; default 0
// - reset bits return to 1 once their reset has begun
// - a subsystem reset completes only while its clock runs
// - wake select 1 (default): select pin falling edge starts sequencing
// - wake select 0: select pin ignored; data pin edge may start it
// - delay codes 0..6 wait 32..256 converter clocks after lock
// - delay code 7 powers receiver at lock; field default 0
// - window codes 0..7 wait 20..36 filter clocks before power down
// - window codes 8..15 wait 40..72 filter clocks; default code 10
// - data pin wakes only with split output, no select, mode 3
// - master reset low loads defaults in all other registers
package rsq_pkg;
    localparam logic [7:0] ADDR_MAIN = 8'h00;
    localparam logic [7:0] ADDR_BLOCK_RST = 8'h02;
    localparam logic [7:0] ADDR_WAKE_CFG = 8'h03;
    localparam logic [7:0] ADDR_RST_DONE = 8'h41;
    localparam logic [7:0] MAIN_DEF = 8'h01;
    localparam logic [7:0] BLOCK_RST_DEF = 8'h00;
    localparam logic [7:0] BLOCK_RST_IDLE = 8'hFF;
    localparam logic [7:0] WAKE_CFG_DEF = 8'h8A;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam int MAIN_RST_BIT = 0;
    localparam int PSEL_BIT = 7;
    localparam int RXW_MSB = 6;
    localparam int RXW_LSB = 4;
    localparam int CSW_MSB = 3;
    localparam int CSW_LSB = 0;
    localparam logic [1:0] SEQ_ENABLE_MODE = 2'h3;
    localparam logic [2:0] RXW_NONE = 3'h7;
    localparam int SUB_COUNT = 8;
    localparam int SUB_HOLD = 2;
    localparam logic [8:0] CNT_ONE = 9'h001;
    // converter clock periods per delay code 0..6
    localparam logic [8:0] RX_WAIT_TICKS [0:6] = '{
        9'h020, 9'h02C, 9'h040, 9'h058, 9'h080, 9'h0B0, 9'h100};
    // filter clock periods per window code; code 12 kept as printed (66)
    localparam logic [6:0] CS_WAIT_TICKS [0:15] = '{
        7'h14, 7'h16, 7'h18, 7'h1A, 7'h1C, 7'h1E, 7'h20, 7'h24,
        7'h28, 7'h2C, 7'h30, 7'h34, 7'h42, 7'h3C, 7'h40, 7'h48};

    typedef struct packed {
        logic adc_rst_n;
        logic gain_ctrl_rst_n;
        logic shaping_filter_rst_n;
        logic freq_correct_rst_n;
        logic modem_sync_rst_n;
        logic synth_digital_rst_n;
        logic powerup_fsm_rst_n;
        logic cal_lock_rst_n;
    } rsq_sub_rst_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rsq_bus_req_t;

    typedef enum logic [2:0] {
        SEQ_POWER_DOWN,
        SEQ_WAIT_LOCK,
        SEQ_LOCK_DELAY,
        SEQ_CS_WINDOW,
        SEQ_RX_ACTIVE
    } rsq_seq_state_t;
endpackage

// file: rtl/rsq_sub_reset.sv
`timescale 1ns/1ps
// one subsystem soft reset: pending until enough running clock edges
module rsq_sub_reset #(
    parameter int HOLD = 2
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start,
    input wire logic clk_run,
    output logic sub_rst_n,
    output logic done
);
    logic pending;
    logic [7:0] cnt;

    // power-up leaves every subsystem pending, like a written zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pending <= 1'b1;
            cnt <= 8'h00;
        end else if (start) begin
            pending <= 1'b1;
            cnt <= 8'h00;
        end else if (pending && clk_run) begin
            cnt <= cnt + 8'h01;
            if (cnt == 8'(HOLD - 1)) begin
                pending <= 1'b0;
            end
        end
    end

    // stopped clock keeps the reset asserted indefinitely
    assign sub_rst_n = ~pending;
    assign done = ~pending;
endmodule

// file: rtl/rsq_top.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module rsq_top #(
    parameter int HOLD = rsq_pkg::SUB_HOLD
) (
    input wire logic mclk,
    input wire logic nrst,
    input rsq_pkg::rsq_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic [7:0] sub_clk_run,
    input wire logic select_pin,
    input wire logic data_io_pin,
    input wire logic split_rx_data_out,
    input wire logic [1:0] powerdown_mode_sel,
    input wire logic synth_lock,
    input wire logic carrier_sense,
    input wire logic adc_clk_tick,
    input wire logic filter_clk_tick,
    output rsq_pkg::rsq_sub_rst_t sub_rst,
    output logic synth_power_up,
    output logic rx_power_up,
    output rsq_pkg::rsq_seq_state_t seq_state
);
    logic [7:0] main_ctrl;
    logic [7:0] block_reset_ctrl;
    logic [7:0] wakeup_timing_cfg;
    logic [7:0] start;
    logic [7:0] sub_rst_v;
    logic [7:0] done_v;
    logic master_rst;
    logic wr_main;
    logic wr_block;
    logic wr_wake;
    logic fsm_rst;
    logic select_pin_wakeup_en;
    logic [2:0] rxw_code;
    logic [3:0] csw_code;
    logic [8:0] rxw_ticks;
    logic [8:0] csw_ticks;
    logic sel_prev;
    logic data_prev;
    logic sel_fall;
    logic data_fall;
    logic trigger;
    logic [8:0] cnt;
    logic [8:0] next_cnt;
    rsq_pkg::rsq_seq_state_t next_state;

    // write decode
    assign wr_main = bus_req.wr && bus_req.addr == rsq_pkg::ADDR_MAIN;
    assign wr_block = bus_req.wr && bus_req.addr == rsq_pkg::ADDR_BLOCK_RST;
    assign wr_wake = bus_req.wr && bus_req.addr == rsq_pkg::ADDR_WAKE_CFG;
    assign master_rst = ~main_ctrl[rsq_pkg::MAIN_RST_BIT];

    // main control keeps its own value through a master reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            main_ctrl <= rsq_pkg::MAIN_DEF;
        end else if (wr_main) begin
            main_ctrl <= bus_req.wdata;
        end
    end

    // a zero bit lives one cycle: the reset starts and the bit returns
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            block_reset_ctrl <= rsq_pkg::BLOCK_RST_DEF;
        end else if (master_rst) begin
            block_reset_ctrl <= rsq_pkg::BLOCK_RST_DEF;
        end else if (wr_block) begin
            block_reset_ctrl <= bus_req.wdata;
        end else begin
            block_reset_ctrl <= rsq_pkg::BLOCK_RST_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wakeup_timing_cfg <= rsq_pkg::WAKE_CFG_DEF;
        end else if (master_rst) begin
            wakeup_timing_cfg <= rsq_pkg::WAKE_CFG_DEF;
        end else if (wr_wake) begin
            wakeup_timing_cfg <= bus_req.wdata;
        end
    end

    // read data registered, one cycle after the strobe only
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata <= rsq_pkg::READ_ZERO;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                rsq_pkg::ADDR_MAIN: rdata <= main_ctrl;
                rsq_pkg::ADDR_BLOCK_RST: rdata <= block_reset_ctrl;
                rsq_pkg::ADDR_WAKE_CFG: rdata <= wakeup_timing_cfg;
                rsq_pkg::ADDR_RST_DONE: rdata <= done_v;
                default: rdata <= rsq_pkg::READ_ZERO;
            endcase
        end else begin
            rdata <= rsq_pkg::READ_ZERO;
        end
    end

    // one reset slice per subsystem, bit i of the control register
    assign start = ~block_reset_ctrl;
    genvar gi;
    generate
        for (gi = 0; gi < rsq_pkg::SUB_COUNT; gi++) begin : g_sub
            rsq_sub_reset #(.HOLD(HOLD)) u_sub (
                .mclk(mclk),
                .nrst(nrst),
                .start(start[gi]),
                .clk_run(sub_clk_run[gi]),
                .sub_rst_n(sub_rst_v[gi]),
                .done(done_v[gi])
            );
        end
    endgenerate

    // subsystem reset outputs, active low
    assign sub_rst.adc_rst_n = sub_rst_v[7];
    assign sub_rst.gain_ctrl_rst_n = sub_rst_v[6];
    assign sub_rst.shaping_filter_rst_n = sub_rst_v[5];
    assign sub_rst.freq_correct_rst_n = sub_rst_v[4];
    assign sub_rst.modem_sync_rst_n = sub_rst_v[3];
    assign sub_rst.synth_digital_rst_n = sub_rst_v[2];
    assign sub_rst.powerup_fsm_rst_n = sub_rst_v[1];
    assign sub_rst.cal_lock_rst_n = sub_rst_v[0];
    assign fsm_rst = ~sub_rst_v[1];

    // configuration fields
    assign select_pin_wakeup_en = wakeup_timing_cfg[rsq_pkg::PSEL_BIT];
    assign rxw_code = wakeup_timing_cfg[rsq_pkg::RXW_MSB:rsq_pkg::RXW_LSB];
    assign csw_code = wakeup_timing_cfg[rsq_pkg::CSW_MSB:rsq_pkg::CSW_LSB];

    // code 7 has no entry; it bypasses the delay state altogether
    always_comb begin
        if (rxw_code == rsq_pkg::RXW_NONE) begin
            rxw_ticks = rsq_pkg::CNT_ONE;
        end else begin
            rxw_ticks = rsq_pkg::RX_WAIT_TICKS[rxw_code];
        end
    end
    assign csw_ticks = {2'b00, rsq_pkg::CS_WAIT_TICKS[csw_code]};

    // edge detect: pins are taken as synchronous already
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sel_prev <= 1'b1;
            data_prev <= 1'b1;
        end else begin
            sel_prev <= select_pin;
            data_prev <= data_io_pin;
        end
    end
    assign sel_fall = sel_prev && !select_pin;
    assign data_fall = data_prev && !data_io_pin;

    // select pin wins when enabled; data pin needs all three conditions
    always_comb begin
        if (select_pin_wakeup_en) begin
            trigger = sel_fall;
        end else begin
            trigger = data_fall && split_rx_data_out
                && powerdown_mode_sel == rsq_pkg::SEQ_ENABLE_MODE;
        end
    end

    // sequencer next state; counts run in slow clock ticks, not mclk cycles
    always_comb begin
        next_state = seq_state;
        next_cnt = cnt;
        unique case (seq_state)
            rsq_pkg::SEQ_POWER_DOWN: begin
                if (trigger) begin
                    next_state = rsq_pkg::SEQ_WAIT_LOCK;
                end
            end
            rsq_pkg::SEQ_WAIT_LOCK: begin
                if (synth_lock && rxw_code == rsq_pkg::RXW_NONE) begin
                    next_state = rsq_pkg::SEQ_CS_WINDOW;
                    next_cnt = csw_ticks;
                end else if (synth_lock) begin
                    next_state = rsq_pkg::SEQ_LOCK_DELAY;
                    next_cnt = rxw_ticks;
                end
            end
            rsq_pkg::SEQ_LOCK_DELAY: begin
                if (adc_clk_tick && cnt == rsq_pkg::CNT_ONE) begin
                    next_state = rsq_pkg::SEQ_CS_WINDOW;
                    next_cnt = csw_ticks;
                end else if (adc_clk_tick) begin
                    next_cnt = cnt - rsq_pkg::CNT_ONE;
                end
            end
            rsq_pkg::SEQ_CS_WINDOW: begin
                if (carrier_sense) begin
                    next_state = rsq_pkg::SEQ_RX_ACTIVE;
                end else if (filter_clk_tick && cnt == rsq_pkg::CNT_ONE) begin
                    next_state = rsq_pkg::SEQ_POWER_DOWN;
                end else if (filter_clk_tick) begin
                    next_cnt = cnt - rsq_pkg::CNT_ONE;
                end
            end
            rsq_pkg::SEQ_RX_ACTIVE: begin
                if (!carrier_sense) begin
                    next_state = rsq_pkg::SEQ_POWER_DOWN;
                end
            end
            default: begin
                next_state = rsq_pkg::SEQ_POWER_DOWN;
            end
        endcase
    end

    // sequencer state, held idle while its soft reset is pending
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            seq_state <= rsq_pkg::SEQ_POWER_DOWN;
            cnt <= 9'h000;
        end else if (fsm_rst) begin
            seq_state <= rsq_pkg::SEQ_POWER_DOWN;
            cnt <= 9'h000;
        end else begin
            seq_state <= next_state;
            cnt <= next_cnt;
        end
    end

    // power controls follow the state, registered for clean outputs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            synth_power_up <= 1'b0;
            rx_power_up <= 1'b0;
        end else if (fsm_rst) begin
            synth_power_up <= 1'b0;
            rx_power_up <= 1'b0;
        end else begin
            synth_power_up <= next_state != rsq_pkg::SEQ_POWER_DOWN;
            rx_power_up <= next_state == rsq_pkg::SEQ_CS_WINDOW
                || next_state == rsq_pkg::SEQ_RX_ACTIVE;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_idle_ready;
        seq_state == rsq_pkg::SEQ_POWER_DOWN && !fsm_rst;
    endsequence

    sequence s_lock_seen;
        seq_state == rsq_pkg::SEQ_WAIT_LOCK && synth_lock && !fsm_rst;
    endsequence

    sequence s_delay_end;
        seq_state == rsq_pkg::SEQ_LOCK_DELAY && !fsm_rst
            && adc_clk_tick && cnt == rsq_pkg::CNT_ONE;
    endsequence

    a_bits_self_clear: assert property (
        wr_block && !master_rst ##1 !wr_block && !master_rst
            |=> block_reset_ctrl == rsq_pkg::BLOCK_RST_IDLE)
        else $error("reset bits did not return to one");

    a_start_holds_rst: assert property (
        (|start) |=> (sub_rst_v & $past(start)) == 8'h00)
        else $error("written reset bit did not assert its reset");

    a_stopped_clk_pend: assert property (
        (sub_rst_v & ~$past(sub_rst_v) & ~$past(sub_clk_run)) == 8'h00)
        else $error("reset finished without a running clock");

    a_done_read_back: assert property (
        bus_req.rd && bus_req.addr == rsq_pkg::ADDR_RST_DONE
            |=> rdata == $past(done_v))
        else $error("done status read wrong");

    a_master_defaults: assert property (
        master_rst |=> wakeup_timing_cfg == rsq_pkg::WAKE_CFG_DEF
            && block_reset_ctrl == rsq_pkg::BLOCK_RST_DEF)
        else $error("master reset did not load defaults");

    a_select_wake: assert property (
        s_idle_ready ##0 select_pin_wakeup_en && sel_fall
            |=> seq_state == rsq_pkg::SEQ_WAIT_LOCK ##1 synth_power_up)
        else $error("select pin edge did not start sequencing");

    a_data_pin_gate: assert property (
        s_idle_ready ##0 data_fall && !sel_fall
            && (select_pin_wakeup_en || !split_rx_data_out
            || powerdown_mode_sel != rsq_pkg::SEQ_ENABLE_MODE)
            |=> seq_state == rsq_pkg::SEQ_POWER_DOWN)
        else $error("data pin edge woke the sequencer wrongly");

    a_data_pin_wake: assert property (
        s_idle_ready ##0 data_fall && !select_pin_wakeup_en
            && split_rx_data_out
            && powerdown_mode_sel == rsq_pkg::SEQ_ENABLE_MODE
            |=> seq_state == rsq_pkg::SEQ_WAIT_LOCK)
        else $error("data pin edge did not start sequencing");

    a_no_wait_code: assert property (
        s_lock_seen ##0 rxw_code == rsq_pkg::RXW_NONE |=> rx_power_up)
        else $error("code 7 did not power receiver at lock");

    a_delay_load: assert property (
        s_lock_seen ##0 rxw_code != rsq_pkg::RXW_NONE
            |=> !rx_power_up && cnt == $past(rxw_ticks))
        else $error("lock delay not loaded");

    a_window_end: assert property (
        s_delay_end |=> rx_power_up && cnt == $past(csw_ticks))
        else $error("window not started after delay");

    a_window_close: assert property (
        seq_state == rsq_pkg::SEQ_CS_WINDOW && !fsm_rst && !carrier_sense
            && filter_clk_tick && cnt == rsq_pkg::CNT_ONE
            |=> !rx_power_up && !synth_power_up)
        else $error("window end did not power down");

    // guards on the refused and ordered steps of the sequencer, and on idle read data
    a_select_ignored: assert property (
        s_idle_ready ##0 !select_pin_wakeup_en && sel_fall && !data_fall
            |=> seq_state == rsq_pkg::SEQ_POWER_DOWN)
        else $error("select pin edge woke with its wake-up off");

    a_fsm_soft_rst: assert property (
        fsm_rst |=> seq_state == rsq_pkg::SEQ_POWER_DOWN
            && !synth_power_up && !rx_power_up)
        else $error("sequencer ran while its reset was pending");

    a_rx_after_lock: assert property (
        seq_state == rsq_pkg::SEQ_WAIT_LOCK && !synth_lock
            |=> !rx_power_up)
        else $error("receiver powered before synthesizer lock");

    a_delay_hold: assert property (
        seq_state == rsq_pkg::SEQ_LOCK_DELAY && !fsm_rst && !adc_clk_tick
            |=> seq_state == rsq_pkg::SEQ_LOCK_DELAY && $stable(cnt))
        else $error("lock delay moved without a converter tick");

    a_rdata_idle: assert property (
        !bus_req.rd |=> rdata == rsq_pkg::READ_ZERO)
        else $error("read data stood longer than one cycle");
endmodule

// file: test/rsq_radio_model.sv
`timescale 1ns/1ps
// analog side stand-in: converter and filter ticks, lock, carrier
module rsq_radio_model #(
    parameter int ADC_DIV = 2,
    parameter int FLT_DIV = 3,
    parameter int LOCK_LAT = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic synth_power_up,
    input wire logic rx_power_up,
    input wire logic carrier_on,
    output logic adc_clk_tick,
    output logic filter_clk_tick,
    output logic synth_lock,
    output logic carrier_sense
);
    int adc_cnt;
    int flt_cnt;
    int lock_cnt;
    // divided clocks, free running, seen as one-cycle pulses
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            adc_cnt <= 0;
            flt_cnt <= 0;
        end else begin
            adc_cnt <= (adc_cnt == ADC_DIV - 1) ? 0 : adc_cnt + 1;
            flt_cnt <= (flt_cnt == FLT_DIV - 1) ? 0 : flt_cnt + 1;
        end
    end
    // lock only after the synthesizer has settled for a while
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lock_cnt <= 0;
        end else if (!synth_power_up) begin
            lock_cnt <= 0;
        end else if (lock_cnt < LOCK_LAT) begin
            lock_cnt <= lock_cnt + 1;
        end
    end
    assign adc_clk_tick = (adc_cnt == ADC_DIV - 1);
    assign filter_clk_tick = (flt_cnt == FLT_DIV - 1);
    assign synth_lock = synth_power_up && (lock_cnt == LOCK_LAT);
    // a receiver that is off cannot sense a carrier
    assign carrier_sense = carrier_on & rx_power_up;
endmodule

// file: test/rsq_top_test.sv
`timescale 1ns/1ps
module rsq_top_test;
    logic mclk, nrst, select_pin, data_io_pin, split_rx_data_out;
    logic synth_lock, carrier_sense, adc_clk_tick, filter_clk_tick;
    logic synth_power_up, rx_power_up, carrier_on;
    logic [1:0] powerdown_mode_sel;
    logic [7:0] rdata, sub_clk_run;
    rsq_pkg::rsq_bus_req_t bus_req;
    rsq_pkg::rsq_sub_rst_t sub_rst;
    rsq_pkg::rsq_seq_state_t seq_state;
    int err_count, checked, cyc, d_cnt, w_cnt;
    // every delay code and every window code, code 12 included
    logic [7:0] cfgs [16] = '{8'h8A, 8'hEF, 8'hF0, 8'hB8, 8'h97, 8'hC1,
        8'hA9, 8'hDB, 8'h8D, 8'hFE, 8'hF4, 8'h9C, 8'h82, 8'hF3, 8'hD5,
        8'hE6};
    int dlys [16] = '{32, 256, 0, 88, 44, 128, 64, 176, 32, 0, 0, 44, 32,
        0, 176, 256};
    int wins [16] = '{48, 72, 20, 40, 36, 22, 44, 52, 60, 64, 28, 66, 24,
        26, 30, 32};

    rsq_top rsq_top_i (.mclk(mclk), .nrst(nrst), .bus_req(bus_req),
        .rdata(rdata), .sub_clk_run(sub_clk_run), .select_pin(select_pin),
        .data_io_pin(data_io_pin), .split_rx_data_out(split_rx_data_out),
        .powerdown_mode_sel(powerdown_mode_sel), .synth_lock(synth_lock),
        .carrier_sense(carrier_sense), .adc_clk_tick(adc_clk_tick),
        .filter_clk_tick(filter_clk_tick), .sub_rst(sub_rst),
        .synth_power_up(synth_power_up), .rx_power_up(rx_power_up),
        .seq_state(seq_state));
    rsq_radio_model rsq_radio_model_i (.mclk(mclk), .nrst(nrst),
        .synth_power_up(synth_power_up), .rx_power_up(rx_power_up),
        .carrier_on(carrier_on), .adc_clk_tick(adc_clk_tick),
        .filter_clk_tick(filter_clk_tick), .synth_lock(synth_lock),
        .carrier_sense(carrier_sense));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // tick counts per sequencer phase; also cuts a hang short
    always @(posedge mclk) begin
        cyc++;
        if (seq_state === rsq_pkg::SEQ_LOCK_DELAY && adc_clk_tick) d_cnt++;
        if (seq_state === rsq_pkg::SEQ_CS_WINDOW && filter_clk_tick) w_cnt++;
        if (cyc == 40000) begin
            err_count++;
            summarize();
        end
    end

    task summarize;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // strobe raised after one edge, dropped after the next
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '0;
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req <= '0;
        #1 chk(rdata, exp);
    endtask
    // bounded poll; a read stands only one cycle so each is fresh
    task poll_done;
        int n;
        n = 0;
        while (rdata !== 8'hFF && n < 40) begin
            @(posedge mclk);
            bus_req <= '{addr: rsq_pkg::ADDR_RST_DONE, wdata: 8'h00,
                wr: 1'b0, rd: 1'b1};
            @(posedge mclk);
            bus_req <= '0;
            #1 n++;
        end
        chk(rdata, 8'hFF);
    endtask
    task pulse(input bit on_data);
        @(posedge mclk);
        if (on_data) data_io_pin <= 1'b0;
        else select_pin <= 1'b0;
        repeat (2) @(posedge mclk);
        data_io_pin <= 1'b1;
        select_pin <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task wait_st(input rsq_pkg::rsq_seq_state_t s, input int lim);
        int n;
        n = 0;
        while (seq_state !== s && n < lim) begin
            @(posedge mclk);
            #1 n++;
        end
        chk(9'(seq_state), 9'(s));
    endtask

    task t_defaults;
        #1 chk(sub_rst, 9'h000);
        rchk(rsq_pkg::ADDR_BLOCK_RST, rsq_pkg::BLOCK_RST_IDLE);
        rchk(rsq_pkg::ADDR_WAKE_CFG, rsq_pkg::WAKE_CFG_DEF);
        rchk(8'h10, rsq_pkg::READ_ZERO);
        poll_done();
        chk(sub_rst, 9'h0FF);
        $display("test defaults done");
    endtask
    task t_blockrst;
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            b = ~(8'h01 << i);
            @(posedge mclk);
            sub_clk_run <= b;
            wr(rsq_pkg::ADDR_BLOCK_RST, b);
            repeat (4) @(posedge mclk);
            #1 chk(sub_rst, b);
            rchk(rsq_pkg::ADDR_BLOCK_RST, 8'hFF);
            rchk(rsq_pkg::ADDR_RST_DONE, b);
            @(posedge mclk);
            sub_clk_run <= 8'hFF;
            poll_done();
            chk(sub_rst, 9'h0FF);
        end
        $display("test block reset done");
    endtask
    task t_master;
        wr(rsq_pkg::ADDR_WAKE_CFG, 8'h35);
        rchk(rsq_pkg::ADDR_WAKE_CFG, 8'h35);
        wr(rsq_pkg::ADDR_MAIN, 8'h00);
        rchk(rsq_pkg::ADDR_WAKE_CFG, rsq_pkg::WAKE_CFG_DEF);
        rchk(rsq_pkg::ADDR_BLOCK_RST, rsq_pkg::BLOCK_RST_DEF);
        wr(rsq_pkg::ADDR_WAKE_CFG, 8'h35);
        rchk(rsq_pkg::ADDR_WAKE_CFG, rsq_pkg::WAKE_CFG_DEF);
        chk(sub_rst, 9'h000);
        wr(rsq_pkg::ADDR_MAIN, rsq_pkg::MAIN_DEF);
        poll_done();
        $display("test master reset done");
    endtask
    task t_seq(input logic [7:0] cfg, input int dly, input int win);
        wr(rsq_pkg::ADDR_WAKE_CFG, cfg);
        #1 d_cnt = 0;
        w_cnt = 0;
        pulse(1'b0);
        chk(9'(seq_state), 9'(rsq_pkg::SEQ_WAIT_LOCK));
        chk(9'(synth_power_up), 9'h001);
        wait_st(rsq_pkg::SEQ_CS_WINDOW, 700);
        chk(9'(rx_power_up), 9'h001);
        wait_st(rsq_pkg::SEQ_POWER_DOWN, 400);
        chk(9'(d_cnt), 9'(dly));
        chk(9'(w_cnt), 9'(win));
        chk({synth_power_up, rx_power_up}, 9'h000);
        $display("test sequence %h done", cfg);
    endtask
    task t_datapin;
        wr(rsq_pkg::ADDR_WAKE_CFG, 8'h0A);
        pulse(1'b0);
        chk(9'(seq_state), 9'(rsq_pkg::SEQ_POWER_DOWN));
        pulse(1'b1);
        chk(9'(seq_state), 9'(rsq_pkg::SEQ_POWER_DOWN));
        @(posedge mclk);
        split_rx_data_out <= 1'b1;
        powerdown_mode_sel <= 2'h2;
        pulse(1'b1);
        chk(9'(seq_state), 9'(rsq_pkg::SEQ_POWER_DOWN));
        @(posedge mclk);
        powerdown_mode_sel <= 2'h3;
        carrier_on <= 1'b1;
        pulse(1'b1);
        chk(9'(seq_state), 9'(rsq_pkg::SEQ_WAIT_LOCK));
        wait_st(rsq_pkg::SEQ_RX_ACTIVE, 400);
        chk(9'(rx_power_up), 9'h001);
        @(posedge mclk);
        carrier_on <= 1'b0;
        wait_st(rsq_pkg::SEQ_POWER_DOWN, 10);
        $display("test data pin wake done");
    endtask

    // reset held 20 cycles, then the scenarios in turn
    initial begin
        nrst = 1'b0;
        bus_req = '0;
        sub_clk_run = 8'hFF;
        select_pin = 1'b1;
        data_io_pin = 1'b1;
        split_rx_data_out = 1'b0;
        powerdown_mode_sel = 2'h3;
        carrier_on = 1'b0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        t_defaults();
        t_blockrst();
        t_master();
        for (int k = 0; k < 16; k++) t_seq(cfgs[k], dlys[k], wins[k]);
        t_datapin();
        summarize();
    end
endmodule
